// [logic/pcicc_regs.sv]
// pci configuration command/status and class/revision registers
//
// Function
// - capability bit mirrors general status bit 19
// - address parity error drives serr when enabled
// - parity response disabled: errors only set the flag, except address errors with serr enabled
// - parity response enabled: raise system error
// - bus master enable gates mastering, resets one
// - memory enable gates memory responses, resets one
// - io bit zero enables io decode, resets one
// - base class reads 02h, writes ignored
// - subclass reads 00h, read only
// - revision field fixed, writes ignored
// - parity flag sets on every detected error
module pcicc_regs
  import pcicc_pkg::*;
#(
  parameter logic [3:0] REVISION = 4'h1             // revision code, value arbitrary
)
(
  input  wire logic        clk,          // pci clock
  input  wire logic        rst,          // pci reset, synchronous, active high
  input  wire logic        cfg_rd,       // configuration read strobe
  input  wire logic        cfg_wr,       // configuration write strobe
  input  wire logic [7:0]  cfg_addr,     // dword byte offset
  input  wire logic [3:0]  cfg_be,       // byte enables, active high
  input  wire logic [31:0] cfg_wdata,    // write data
  output logic      [31:0] cfg_rdata,    // read data, registered
  output logic             cfg_rvalid,   // read data valid pulse
  input  wire logic [31:0] general_status_reg, // status word from the csr block
  input  wire logic        parity_err_det,     // parity error detected pulse
  input  wire logic        addr_phase,         // the error was in an address phase
  input  wire logic        master_req,         // internal engine wants the bus
  input  wire logic        mem_hit,            // memory base address matched
  input  wire logic        io_hit,             // i/o base address matched
  output logic             master_ok,          // mastering permitted and requested
  output logic             mem_respond,        // claim the memory access
  output logic             io_respond,         // claim the i/o access
  output logic             serr_n,             // system error pin, active low
  output logic             io_en_reg_o,        // raw io_space_enable bit
  output logic             bme_o               // bus master enable level
);
  pcicc_err_if eif ();                     // tracker carrier

  logic io_en_reg;                         // io_space_enable, 0 decodes
  logic mem_en_reg;                        // memory_space_enable
  logic bme_reg;                           // bus master enable
  logic pre_reg;                           // parity_response_enable
  logic serr_en_reg;                       // addr_parity_serr_enable
  logic pe_flag_reg;                       // parity_error_flag
  logic sys_err_reg;                       // system error indication
  logic cmd_wr;                            // write hits command word
  logic [31:0] cmd_word;                   // assembled command/status view
  logic [31:0] class_word;                 // class/revision view

  pcicc_err_track u_trk (
    .clk            (clk),
    .rst            (rst),
    .parity_err_det (parity_err_det),
    .addr_phase     (addr_phase),
    .eif            (eif)
  );

  assign eif.parity_resp_en = pre_reg;
  assign eif.serr_en        = serr_en_reg;
  assign cmd_wr             = cfg_wr && (cfg_addr == CMD_STAT_OFS);

  // ************************************************************
  // command bits
  // ************************************************************
  // byte lane 0 holds the decode and parity enables
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      io_en_reg  <= IO_EN_RST;
      mem_en_reg <= MEM_EN_RST;
      bme_reg    <= BME_RST;
      pre_reg    <= PRE_RST;
    end
    else if (cmd_wr && cfg_be[0])
    begin
      bme_reg    <= cfg_wdata[BME_BIT];
      mem_en_reg <= cfg_wdata[MEM_EN_BIT];
      io_en_reg  <= cfg_wdata[IO_EN_BIT];
      pre_reg    <= cfg_wdata[PRE_BIT];
    end
  end

  // byte lane 1 holds the address parity serr enable
  always_ff @(posedge clk)
  begin
    if (rst)
      serr_en_reg <= SERR_EN_RST;
    else if (cmd_wr && cfg_be[1])
      serr_en_reg <= cfg_wdata[SERR_EN_BIT];
  end

  // ************************************************************
  // status flags, write one to clear; a new event wins over the clear
  // ************************************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pe_flag_reg <= 1'b0;
      sys_err_reg <= 1'b0;
    end
    else
    begin
      if (eif.pe_set)
        pe_flag_reg <= 1'b1;
      else if (cmd_wr && cfg_be[3] && cfg_wdata[PE_FLAG_BIT])
        pe_flag_reg <= 1'b0;
      if (eif.sys_err_set)
        sys_err_reg <= 1'b1;
      else if (cmd_wr && cfg_be[3] && cfg_wdata[SYS_ERR_BIT])
        sys_err_reg <= 1'b0;
    end
  end

  // ************************************************************
  // read views
  // ************************************************************
  always_comb
  begin
    cmd_word = ZERO_WORD;
    cmd_word[PE_FLAG_BIT] = pe_flag_reg;
    cmd_word[SYS_ERR_BIT] = sys_err_reg;
    cmd_word[CAP_BIT]     = general_status_reg[GSR_CAP_BIT];
    cmd_word[SERR_EN_BIT] = serr_en_reg;
    cmd_word[PRE_BIT]     = pre_reg;
    cmd_word[BME_BIT]     = bme_reg;
    cmd_word[MEM_EN_BIT]  = mem_en_reg;
    cmd_word[IO_EN_BIT]   = io_en_reg;
    class_word = ZERO_WORD;
    class_word[BASE_LSB +: 8] = BASE_CLASS;
    class_word[SUB_LSB +: 8]  = SUB_CLASS;
    class_word[REV_LSB +: 4]  = REVISION;
  end

  // read data is registered, one cycle after the strobe; unmapped offsets read zero
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cfg_rdata  <= ZERO_WORD;
      cfg_rvalid <= 1'b0;
    end
    else
    begin
      cfg_rvalid <= cfg_rd;
      if (cfg_rd)
      begin
        case (cfg_addr)
          CMD_STAT_OFS:  cfg_rdata <= cmd_word;
          CLASS_REV_OFS: cfg_rdata <= class_word;
          default:       cfg_rdata <= ZERO_WORD;
        endcase
      end
    end
  end

  // ************************************************************
  // gated outputs, all registered so they lag the enables by one cycle
  // ************************************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      master_ok   <= 1'b0;
      mem_respond <= 1'b0;
      io_respond  <= 1'b0;
      serr_n      <= 1'b1;
      io_en_reg_o <= IO_EN_RST;
      bme_o       <= BME_RST;
    end
    else
    begin
      master_ok   <= master_req & bme_reg;
      mem_respond <= mem_hit & mem_en_reg;
      io_respond  <= io_hit & ~io_en_reg;
      serr_n      <= ~eif.serr_fire;
      io_en_reg_o <= io_en_reg;
      bme_o       <= bme_reg;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_master_gate: assert property (master_ok |-> ($past(bme_reg) && $past(master_req)))
    else $error("master permitted while disabled");
  a_mem_gate: assert property ((mem_hit && !mem_en_reg) |=> !mem_respond)
    else $error("memory claimed while disabled");
  a_io_polarity: assert property ((io_hit && !io_en_reg) |=> io_respond)
    else $error("io not claimed with io bit zero");
  a_class_const: assert property ((cfg_rd && cfg_addr == CLASS_REV_OFS) |=>
    (cfg_rvalid && cfg_rdata[31:16] == 16'h0200))
    else $error("class code read wrong");
  a_rev_fixed: assert property ((cfg_rd && cfg_addr == CLASS_REV_OFS) |=> (cfg_rdata[7:4] == REVISION))
    else $error("revision read wrong");
  a_cap_mirror: assert property ((cfg_rd && cfg_addr == CMD_STAT_OFS) |=>
    (cfg_rdata[CAP_BIT] == $past(general_status_reg[GSR_CAP_BIT])))
    else $error("capability bit not mirrored");
  a_reserved_zero: assert property ((cfg_rd && cfg_addr == CMD_STAT_OFS) |=>
    (cfg_rdata[29:21] == 9'h000 && cfg_rdata[19:9] == 11'h000))
    else $error("reserved command bits not zero");
  // the flag may only drop through a clear that no new event overrides
  a_pe_sticky: assert property (parity_err_det |=> pe_flag_reg ##1
    (pe_flag_reg || $past(cmd_wr && cfg_be[3] && cfg_wdata[PE_FLAG_BIT] && !eif.pe_set)))
    else $error("parity flag lost");
  // back to back address errors keep the pin low, a lone one gives one low cycle
  a_serr_pin: assert property ((parity_err_det && addr_phase && serr_en_reg) |=>
    !serr_n ##1 (serr_n || $past(eif.serr_fire)))
    else $error("serr pulse wrong");

  c_serr_seen:  cover property (!serr_n);
  c_io_claim:   cover property (io_respond);
  c_flag_clear: cover property (pe_flag_reg ##1 !pe_flag_reg);
  c_master_off: cover property (master_req && !bme_reg);
endmodule

// [logic/pcicc_pkg.sv]
// constants for the pci command and class/revision configuration registers
package pcicc_pkg;
  // ************************************************************
  // register offsets (byte addresses of configuration dwords)
  // ************************************************************
  localparam logic [7:0] CMD_STAT_OFS  = 8'h04;      // command_status_config
  localparam logic [7:0] CLASS_REV_OFS = 8'h08;      // class_code_revision
  // ************************************************************
  // command/status field positions
  // ************************************************************
  localparam int IO_EN_BIT    = 0;                   // io_space_enable (0 = decode on)
  localparam int MEM_EN_BIT   = 1;                   // memory_space_enable
  localparam int BME_BIT      = 2;                   // bus master enable
  localparam int PRE_BIT      = 6;                   // parity_response_enable
  localparam int SERR_EN_BIT  = 8;                   // addr_parity_serr_enable
  localparam int CAP_BIT      = 20;                  // capability list indicator
  localparam int SYS_ERR_BIT  = 30;                  // system error indication
  localparam int PE_FLAG_BIT  = 31;                  // parity_error_flag
  localparam int GSR_CAP_BIT  = 19;                  // source bit in general_status_reg
  // ************************************************************
  // class/revision field positions and constants
  // ************************************************************
  localparam int BASE_LSB     = 24;                  // base class field low bit
  localparam int SUB_LSB      = 16;                  // subclass_field low bit
  localparam int REV_LSB      = 4;                   // revision_field low bit
  localparam logic [7:0] BASE_CLASS = 8'h02;         // network controller
  localparam logic [7:0] SUB_CLASS  = 8'h00;         // ethernet controller
  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic IO_EN_RST   = 1'b1;               // i/o decode off at reset
  localparam logic MEM_EN_RST  = 1'b1;
  localparam logic BME_RST     = 1'b1;
  localparam logic PRE_RST     = 1'b0;
  localparam logic SERR_EN_RST = 1'b1;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
endpackage

// [logic/pcicc_err_if.sv]
// carrier between the command register top and the parity error tracker
interface pcicc_err_if;
  logic parity_resp_en;   // parity_response_enable from the register
  logic serr_en;          // addr_parity_serr_enable from the register
  logic pe_set;           // set term for parity_error_flag
  logic sys_err_set;      // set term for the system error indication
  logic serr_fire;        // assert the system error pin on the next cycle
  modport regs (output parity_resp_en, output serr_en, input pe_set, input sys_err_set, input serr_fire);
  modport trk  (input parity_resp_en, input serr_en, output pe_set, output sys_err_set, output serr_fire);
endinterface

// [logic/pcicc_err_track.sv]
// parity error tracker: turns detected parity errors into flag and pin events
module pcicc_err_track
  import pcicc_pkg::*;
(
  input  wire logic clk,            // pci clock
  input  wire logic rst,            // synchronous reset, active high
  input  wire logic parity_err_det, // one-cycle pulse, parity error seen
  input  wire logic addr_phase,     // qualifies the pulse as an address phase error
  pcicc_err_if.trk  eif             // enables in, set terms out
);
  // ************************************************************
  // event decode
  // ************************************************************
  always_comb
  begin
    eif.pe_set = parity_err_det;
    // gated by enable: with the response enable clear only the flag moves, except for address errors with serr_en set
    eif.sys_err_set = parity_err_det & (eif.parity_resp_en | (addr_phase & eif.serr_en));
    eif.serr_fire = parity_err_det & addr_phase & eif.serr_en;
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // a system error event with no flag event would leave the status word inconsistent
  a_flag_follows_err: assert property ((eif.sys_err_set || eif.serr_fire) |-> eif.pe_set)
    else $error("error event without parity flag set term");
  a_quiet_when_off: assert property ((!eif.parity_resp_en && !addr_phase) |-> !eif.sys_err_set)
    else $error("system error raised with parity response disabled");
  a_sys_err_on: assert property ((parity_err_det && eif.parity_resp_en) |-> eif.sys_err_set)
    else $error("system error not raised with parity response enabled");
  // the pin event must also be recorded as a system error indication
  a_serr_cause: assert property ((parity_err_det && addr_phase && eif.serr_en) |-> (eif.serr_fire && eif.sys_err_set))
    else $error("enabled address parity error did not fire serr");
endmodule

// [tb/pcicc_host.sv]
// host bridge model issuing configuration reads and writes
module pcicc_host
(
  input  wire logic        clk,        // pci clock
  output logic             cfg_rd,     // read strobe
  output logic             cfg_wr,     // write strobe
  output logic [7:0]       cfg_addr,   // dword offset
  output logic [3:0]       cfg_be,     // byte enables
  output logic [31:0]      cfg_wdata,  // write data
  input  wire logic [31:0] cfg_rdata,  // read data
  input  wire logic        cfg_rvalid  // read data valid
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus: strobes low, address at ff, byte enables and data zero
  initial
  begin
    cfg_rd    = 1'b0;
    cfg_wr    = 1'b0;
    cfg_addr  = 8'hff;
    cfg_be    = 4'h0;
    cfg_wdata = 32'h0000_0000;
  end
  // drop the strobe and scramble the qualifiers after the taking edge
  task automatic release_bus;
    cfg_rd    = 1'b0;
    cfg_wr    = 1'b0;
    cfg_addr  = ~cfg_addr;
    cfg_be    = ~cfg_be;
    cfg_wdata = ~cfg_wdata;
  endtask
  // one write cycle, taken at the next rising edge
  task automatic cfg_write(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge clk);
    #1;
    cfg_wr    = 1'b1;
    cfg_addr  = a;
    cfg_be    = be;
    cfg_wdata = d;
    @(posedge clk);
    #1;
    release_bus();
  endtask
  // one read cycle; the valid pulse stands only one cycle after the taking edge, the data until the next read
  task automatic cfg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    #1;
    cfg_rd   = 1'b1;
    cfg_addr = a;
    @(posedge clk);
    #1;
    d = (cfg_rvalid === 1'b1) ? cfg_rdata : 'x;
    release_bus();
  endtask
endmodule

// [tb/tb.sv]
// self-checking testbench of the command and class/revision registers
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pcicc_pkg::*;
  localparam logic [3:0] REV = 4'h5;  // revision code, value arbitrary
  logic        clk, rst, cfg_rd, cfg_wr, cfg_rvalid;
  logic [7:0]  cfg_addr;
  logic [3:0]  cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata, gsr, rd, wd, m, cmd_exp;
  logic        ped, aph, mreq, mhit, ihit, master_ok, mem_respond, io_respond, serr_n, io_o, bme_o;
  int          err_count, n_tests;
  integer      seed;
  pcicc_host i_pcicc_host (.clk(clk), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid));
  pcicc_regs #(.REVISION(REV)) i_pcicc_regs (.clk(clk), .rst(rst), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
    .general_status_reg(gsr), .parity_err_det(ped), .addr_phase(aph), .master_req(mreq), .mem_hit(mhit),
    .io_hit(ihit), .master_ok(master_ok), .mem_respond(mem_respond), .io_respond(io_respond), .serr_n(serr_n),
    .io_en_reg_o(io_o), .bme_o(bme_o));
  // ************************************************************
  // clock, checks and closing
  // ************************************************************
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // command word as the host should see it, mirror bit folded in
  function automatic logic [31:0] cmd_view(input logic [31:0] c, input logic [31:0] g);
    return c | {11'h000, g[GSR_CAP_BIT], 20'h0_0000};
  endfunction
  task automatic rd_cmd;
    i_pcicc_host.cfg_read(CMD_STAT_OFS, rd);
    check(rd, cmd_view(cmd_exp, gsr));
    // data stands after the valid pulse
    @(posedge clk);
    #1;
    check({31'h0, cfg_rvalid}, 32'h0000_0000);
    check(cfg_rdata, cmd_view(cmd_exp, gsr));
  endtask
  // one parity detection; serr_n is looked at in its single low cycle and after
  task automatic pulse(input logic ap, input logic serr_exp);
    @(posedge clk);
    #1;
    ped = 1'b1;
    aph = ap;
    @(posedge clk);
    #1;
    ped = 1'b0;
    check({31'h0, serr_n}, {31'h0, serr_exp});
    @(posedge clk);
    #1;
    check({31'h0, serr_n}, 32'h0000_0001);
  endtask
  // watchdog: the whole run needs well under a few thousand cycles
  initial
  begin
    #200000;
    err_count++;
    end_of_test();
  end
  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    seed = 32'hc9b5_76b2;
    err_count = 0;
    n_tests = 0;
    {rst, ped, aph, mreq, mhit, ihit} = 6'h3f & 6'h20;
    gsr = $random(seed);
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
    cmd_exp = 32'h0000_0107;
    check({30'h0, io_o, bme_o}, 32'h0000_0003);
    rd_cmd();
    for (int k = 0; k < 2; k++)
    begin
      i_pcicc_host.cfg_read(CLASS_REV_OFS, rd);
      check(rd, {BASE_CLASS, SUB_CLASS, 8'h00, REV, 4'h0});
      i_pcicc_host.cfg_write(CLASS_REV_OFS, 4'hf, 32'hffff_ffff);
    end
    // unmapped offset reads zero and leaves the command word alone
    i_pcicc_host.cfg_write(8'h0c, 4'hf, 32'h0000_0000);
    i_pcicc_host.cfg_read(8'h0c, rd);
    check(rd, 32'h0000_0000);
    rd_cmd();
    // enables gate the outputs, corners first
    for (int i = 0; i < 24; i++)
    begin
      wd = (i == 0) ? 32'h0000_0000 : (i == 1) ? 32'hffff_ffff : $random(seed);
      m = (i < 2) ? 32'h0000_000f : $random(seed);
      i_pcicc_host.cfg_write(CMD_STAT_OFS, m[3:0], wd);
      m = (m[0] ? 32'h0000_0047 : 32'h0000_0000) | (m[1] ? 32'h0000_0100 : 32'h0000_0000);
      cmd_exp = (cmd_exp & ~m) | (wd & m);
      {mreq, mhit, ihit} = 3'($random(seed));
      gsr = $random(seed);
      @(posedge clk);
      #1;
      check({29'h0, master_ok, mem_respond, io_respond},
        {29'h0, mreq & cmd_exp[2], mhit & cmd_exp[1], ihit & ~cmd_exp[0]});
      check({30'h0, io_o, bme_o}, {30'h0, cmd_exp[0], cmd_exp[2]});
      rd_cmd();
    end
    i_pcicc_host.cfg_write(CMD_STAT_OFS, 4'h3, 32'h0000_0000);
    cmd_exp = 32'h0000_0000;
    pulse(1'b1, 1'b1);
    cmd_exp = 32'h8000_0000;
    rd_cmd();
    i_pcicc_host.cfg_write(CMD_STAT_OFS, 4'h8, 32'h8000_0000);
    cmd_exp = 32'h0000_0000;
    rd_cmd();
    i_pcicc_host.cfg_write(CMD_STAT_OFS, 4'h1, 32'h0000_0040);
    pulse(1'b0, 1'b1);
    cmd_exp = 32'hc000_0040;
    rd_cmd();
    i_pcicc_host.cfg_write(CMD_STAT_OFS, 4'hf, 32'hc000_0140);
    pulse(1'b1, 1'b0);
    cmd_exp = 32'hc000_0140;
    rd_cmd();
    // pin path alone, parity response off, flags cleared first
    i_pcicc_host.cfg_write(CMD_STAT_OFS, 4'hb, 32'hc000_0100);
    pulse(1'b1, 1'b0);
    cmd_exp = 32'hc000_0100;
    rd_cmd();
    // data-phase error with response off: only the flag moves
    i_pcicc_host.cfg_write(CMD_STAT_OFS, 4'h8, 32'hc000_0000);
    pulse(1'b0, 1'b1);
    cmd_exp = 32'h8000_0100;
    rd_cmd();
    end_of_test();
  end
endmodule
